// *** src/rlb_pkg.sv ***
`default_nettype none
package rlb_pkg;

    // ==========================================================
    // Sizes and timing
    // ==========================================================
    localparam int LT_COUNT_DEF     = 8;
    localparam int OPTO_COUNT_DEF   = 6;
    localparam int CLK_PERIOD_NS    = 100;
    localparam int INTERVAL_NS      = 1_000_000;
    localparam int INTERVAL_CYC_DEF = (INTERVAL_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int DEB_TICKS_DEF    = 2;
    localparam int CHANGES_PER_DAY  = 70;
    localparam int DAYS_PER_YEAR    = 365;
    localparam int LIFE_YEARS       = 25;
    localparam int ENDURANCE_DEF    = CHANGES_PER_DAY * DAYS_PER_YEAR
                                      * LIFE_YEARS;
    localparam int WCOUNT_W         = 20;

    // ==========================================================
    // Nonvolatile store layout
    // ==========================================================
    localparam int          NV_DEPTH    = 2;
    localparam int          NV_WIDTH    = 32;
    localparam logic        NV_ADDR_LT  = 1'h0;
    localparam logic        NV_ADDR_CNT = 1'h1;
    localparam logic [15:0] NV_MARK     = 16'h5a3c;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] REG_RB_ON    = 8'h00;
    localparam logic [7:0] REG_RB_PULSE = 8'h04;
    localparam logic [7:0] REG_LATCH    = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam logic [7:0] REG_WCOUNT   = 8'h10;
    localparam int         STAT_RUN_BIT = 0;
    localparam int         STAT_FAIL_BIT = 1;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        PH_RD_LT  = 2'b00,
        PH_RD_CNT = 2'b01,
        PH_LOAD   = 2'b10,
        PH_RUN    = 2'b11
    } rlb_phase_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } rlb_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rlb_axi_rsp_t;

endpackage : rlb_pkg
`default_nettype wire

// *** src/rlb_nv_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module rlb_nv_store #(
    parameter int W     = 32,
    parameter int DEPTH = 2
) (
    input  wire logic                     aclk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [W-1:0]             wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [W-1:0]             rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } rlb_nv_t;

    rlb_nv_t s_ff;
    rlb_nv_t nxt_s;

    // ==========================================================
    // Storage
    // ==========================================================
    // No reset: contents model nonvolatile cells across power loss
    always_comb begin
        nxt_s    = s_ff;
        nxt_s.rd = s_ff.mem[raddr];
        if (we) begin
            nxt_s.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge aclk) begin
        s_ff <= nxt_s;
    end

    assign rdata = s_ff.rd;

endmodule : rlb_nv_store
`default_nettype wire

// *** src/rlb_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module rlb_debounce import rlb_pkg::*; #(
    parameter int N         = 6,
    parameter int DEB_TICKS = 2
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         tick,
    input  wire logic [N-1:0] raw,
    output logic      [N-1:0] deb
);
    localparam int CW = $clog2(DEB_TICKS) + 1;

    typedef struct packed {
        logic [N-1:0][CW-1:0] cnt;
        logic [N-1:0]         deb;
    } rlb_deb_t;

    rlb_deb_t s_ff;
    rlb_deb_t nxt_s;

    // ==========================================================
    // Pickup and dropout qualification, counted in intervals
    // ==========================================================
    always_comb begin
        nxt_s = s_ff;
        for (int i = 0; i < N; i++) begin
            if (raw[i] == s_ff.deb[i]) begin
                nxt_s.cnt[i] = '0;
            end else if (tick) begin
                if (s_ff.cnt[i] == CW'(DEB_TICKS - 1)) begin
                    nxt_s.deb[i] = raw[i];
                    nxt_s.cnt[i] = '0;
                end else begin
                    nxt_s.cnt[i] = s_ff.cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign deb = s_ff.deb;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_deb_qualified;
        (tick && raw != s_ff.deb
         && s_ff.cnt[0] == CW'(DEB_TICKS - 1) && raw[0] != s_ff.deb[0])
        |=> deb[0] == $past(raw[0]);
    endproperty
    a_deb_qualified: assert property (p_deb_qualified)
        else $error("debounced input did not follow after qualification");

endmodule : rlb_debounce
`default_nettype wire

// *** src/rlb_latch_bank.sv ***
// Notes on behaviour
// - Bank holds 8 or 16 latch bits, each with own set/clear terms.
// - Set term alone drives the latch bit to 1 and holds it.
// - Clear term clears the bit, even when set is also high.
// - Rising-edge operator gives 1 for one interval on 0-to-1.
// - A set in one interval shows on the bit next interval.
// - A held input toggles the latch only once; pulse already expired.
// - Latch bits survive power loss exactly as they were.
// - Settings edits and group switches leave latch bits unchanged.
// - Edits to an idle group never pause evaluation or touch bits.
// - New equations act on the retained values after a change.
// - Average of 70 changes a day over 25 years; overuse flags fail.
// - Opto inputs reach equations only after their debounce timer.
// - Momentary remote bit reads 1 for one interval, then 0.
// - Contacts stay de-energized until the stored state is restored.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rlb_latch_bank import rlb_pkg::*; #(
    parameter int N            = LT_COUNT_DEF,
    parameter int NOPTO        = OPTO_COUNT_DEF,
    parameter int INTERVAL_CYC = INTERVAL_CYC_DEF,
    parameter int DEB_TICKS    = DEB_TICKS_DEF,
    parameter int ENDURANCE    = ENDURANCE_DEF
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire rlb_axi_req_t     axi_req,
    output var  rlb_axi_rsp_t     axi_rsp,
    input  wire logic [N-1:0]     latch_assert_term,
    input  wire logic [N-1:0]     latch_clear_term,
    input  wire logic [N-1:0]     edge_operand,
    input  wire logic [NOPTO-1:0] opto_input,
    output logic      [N-1:0]     retained_latch_bit,
    output logic      [N-1:0]     latch_contact_drive,
    output logic      [N-1:0]     edge_pulse,
    output logic      [N-1:0]     remote_bit,
    output logic      [NOPTO-1:0] opto_debounced,
    output logic                  interval_tick,
    output logic                  restore_done,
    output logic                  storage_fail
);
    localparam int TW = $clog2(INTERVAL_CYC) + 1;

    typedef struct packed {
        rlb_phase_t            ph;
        logic [TW-1:0]         tick_cnt;
        logic                  tick;
        logic                  nv_ok;
        logic                  done;
        logic [N-1:0]          lt;
        logic [N-1:0]          drive;
        logic [N-1:0]          edge_q;
        logic [N-1:0]          edge_p;
        logic [N-1:0]          rb_on;
        logic [N-1:0]          rb_pend;
        logic [N-1:0]          rb_mom;
        logic [N-1:0]          rb_out;
        logic [WCOUNT_W-1:0]   wcount;
        logic                  cnt_pend;
        logic                  fail;
        logic                  nv_we;
        logic                  nv_waddr;
        logic [NV_WIDTH-1:0]   nv_wdata;
        logic                  nv_raddr;
        logic                  aw_got;
        logic [7:0]            aw_addr;
        logic                  w_got;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        rlb_axi_rsp_t          rsp;
    } rlb_core_t;

    rlb_core_t           s_ff;
    rlb_core_t           nxt_s;
    logic [NV_WIDTH-1:0] nv_rdata;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    function automatic logic reg_known(input logic [7:0] a);
        return a == REG_RB_ON || a == REG_RB_PULSE || a == REG_LATCH
            || a == REG_STATUS || a == REG_WCOUNT;
    endfunction : reg_known

    // ==========================================================
    // Submodules
    // ==========================================================
    rlb_nv_store #(
        .W     (NV_WIDTH),
        .DEPTH (NV_DEPTH)
    ) u_nv (
        .aclk  (aclk),
        .we    (s_ff.nv_we),
        .waddr (s_ff.nv_waddr),
        .wdata (s_ff.nv_wdata),
        .raddr (s_ff.nv_raddr),
        .rdata (nv_rdata)
    );

    rlb_debounce #(
        .N         (NOPTO),
        .DEB_TICKS (DEB_TICKS)
    ) u_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (s_ff.tick),
        .raw     (opto_input),
        .deb     (opto_debounced)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.tick     = 1'b0;
        nxt_s.nv_we    = 1'b0;

        // Processing interval timebase
        if (s_ff.tick_cnt == TW'(INTERVAL_CYC - 1)) begin
            nxt_s.tick_cnt = '0;
            nxt_s.tick     = 1'b1;
        end else begin
            nxt_s.tick_cnt = s_ff.tick_cnt + 1'b1;
        end

        // Edge operator and momentary remote bits run every interval
        if (s_ff.tick) begin
            nxt_s.edge_q  = edge_operand;
            nxt_s.edge_p  = edge_operand & ~s_ff.edge_q;
            nxt_s.rb_mom  = s_ff.rb_pend;
            nxt_s.rb_pend = '0;
        end

        case (s_ff.ph)
            PH_RD_LT: begin
                nxt_s.nv_raddr = NV_ADDR_CNT;
                nxt_s.ph       = PH_RD_CNT;
            end
            PH_RD_CNT: begin
                // Blank store (no mark) starts all bits cleared
                if (nv_rdata[31:16] == NV_MARK) begin
                    nxt_s.nv_ok = 1'b1;
                    nxt_s.lt    = nv_rdata[N-1:0];
                end
                nxt_s.ph = PH_LOAD;
            end
            PH_LOAD: begin
                if (s_ff.nv_ok) begin
                    nxt_s.wcount = nv_rdata[WCOUNT_W-1:0];
                end
                nxt_s.ph = PH_RUN;
            end
            PH_RUN: begin
                if (s_ff.cnt_pend) begin
                    nxt_s.nv_we    = 1'b1;
                    nxt_s.nv_waddr = NV_ADDR_CNT;
                    nxt_s.nv_wdata = NV_WIDTH'(s_ff.wcount);
                    nxt_s.cnt_pend = 1'b0;
                end
                // Only the equations move the bits; settings have no path
                if (s_ff.tick) begin
                    nxt_s.lt = (s_ff.lt | latch_assert_term)
                             & ~latch_clear_term;
                    if (nxt_s.lt != s_ff.lt) begin
                        nxt_s.nv_we    = 1'b1;
                        nxt_s.nv_waddr = NV_ADDR_LT;
                        nxt_s.nv_wdata = {NV_MARK, 16'(nxt_s.lt)};
                        nxt_s.cnt_pend = 1'b1;
                        if (s_ff.wcount != '1) begin
                            nxt_s.wcount = s_ff.wcount + 1'b1;
                        end
                    end
                end
                if (32'(s_ff.wcount) >= ENDURANCE) begin
                    nxt_s.fail = 1'b1;
                end
                nxt_s.drive = s_ff.lt;
            end
            default: begin
                nxt_s.ph = PH_RD_LT;
            end
        endcase
        nxt_s.done = (nxt_s.ph == PH_RUN);

        // AXI4-Lite write path
        if (axi_req.awvalid && s_ff.rsp.awready) begin
            nxt_s.aw_got  = 1'b1;
            nxt_s.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_ff.rsp.wready) begin
            nxt_s.w_got  = 1'b1;
            nxt_s.w_data = axi_req.wdata;
            nxt_s.w_strb = axi_req.wstrb;
        end
        if (s_ff.rsp.bvalid && axi_req.bready) begin
            nxt_s.rsp.bvalid = 1'b0;
        end
        if (s_ff.aw_got && s_ff.w_got && !s_ff.rsp.bvalid) begin
            nxt_s.aw_got     = 1'b0;
            nxt_s.w_got      = 1'b0;
            nxt_s.rsp.bvalid = 1'b1;
            nxt_s.rsp.bresp  = reg_known(s_ff.aw_addr) ? RESP_OKAY
                                                       : RESP_SLVERR;
            if (s_ff.aw_addr == REG_RB_ON) begin
                nxt_s.rb_on = N'(wmerge(32'(s_ff.rb_on), s_ff.w_data,
                                        s_ff.w_strb));
            end else if (s_ff.aw_addr == REG_RB_PULSE) begin
                // Set wins over the interval clear above
                nxt_s.rb_pend = nxt_s.rb_pend
                              | N'(wmerge(32'h0, s_ff.w_data, s_ff.w_strb));
            end
        end
        nxt_s.rsp.awready = !nxt_s.aw_got && !nxt_s.rsp.bvalid;
        nxt_s.rsp.wready  = !nxt_s.w_got && !nxt_s.rsp.bvalid;
        nxt_s.rb_out      = nxt_s.rb_on | nxt_s.rb_mom;

        // AXI4-Lite read path
        if (s_ff.rsp.rvalid && axi_req.rready) begin
            nxt_s.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s_ff.rsp.arready) begin
            nxt_s.rsp.rvalid = 1'b1;
            nxt_s.rsp.rresp  = reg_known(axi_req.araddr) ? RESP_OKAY
                                                         : RESP_SLVERR;
            nxt_s.rsp.rdata  = 32'h0;
            if (axi_req.araddr == REG_RB_ON) begin
                nxt_s.rsp.rdata = 32'(s_ff.rb_on);
            end else if (axi_req.araddr == REG_LATCH) begin
                nxt_s.rsp.rdata = 32'(s_ff.lt);
            end else if (axi_req.araddr == REG_STATUS) begin
                nxt_s.rsp.rdata[STAT_RUN_BIT]  = s_ff.ph == PH_RUN;
                nxt_s.rsp.rdata[STAT_FAIL_BIT] = s_ff.fail;
            end else if (axi_req.araddr == REG_WCOUNT) begin
                nxt_s.rsp.rdata = 32'(s_ff.wcount);
            end
        end
        nxt_s.rsp.arready = !nxt_s.rsp.rvalid;
    end

    // Remote bits are volatile; latch bits come back from the store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign axi_rsp             = s_ff.rsp;
    assign retained_latch_bit  = s_ff.lt;
    assign latch_contact_drive = s_ff.drive;
    assign edge_pulse          = s_ff.edge_p;
    assign remote_bit          = s_ff.rb_out;
    assign interval_tick       = s_ff.tick;
    assign restore_done        = s_ff.done;
    assign storage_fail        = s_ff.fail;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_restore;
        s_ff.ph == PH_RD_LT ##1 s_ff.ph == PH_RD_CNT
        ##1 s_ff.ph == PH_LOAD ##1 s_ff.ph == PH_RUN;
    endsequence

    property p_restore;
        $rose(aresetn) |-> s_restore;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore sequence did not complete in three cycles");

    property p_eval;
        (s_ff.tick && s_ff.ph == PH_RUN) |=> retained_latch_bit ==
            (($past(retained_latch_bit) | $past(latch_assert_term))
             & ~$past(latch_clear_term));
    endproperty
    a_eval: assert property (p_eval)
        else $error("latch update does not match set and clear terms");

    property p_hold;
        (!s_ff.tick && s_ff.ph == PH_RUN) |=> $stable(retained_latch_bit);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch bit moved between interval boundaries");

    property p_edge;
        s_ff.tick |=> edge_pulse == ($past(edge_operand)
                                     & ~$past(s_ff.edge_q));
    endproperty
    a_edge: assert property (p_edge)
        else $error("edge pulse does not match operand transition");

    property p_edge_once;
        (s_ff.tick && |(edge_pulse & edge_operand)) |=>
            (edge_pulse & $past(edge_pulse & edge_operand)) == '0;
    endproperty
    a_edge_once: assert property (p_edge_once)
        else $error("held operand produced a second edge pulse");

    property p_momentary;
        (s_ff.tick && s_ff.rb_pend != '0) |=> (s_ff.rb_mom ==
            $past(s_ff.rb_pend)) ##1 (!s_ff.tick)[*1];
    endproperty
    a_momentary: assert property (p_momentary)
        else $error("momentary remote bit not loaded at the interval");

    property p_mom_clear;
        (s_ff.tick && s_ff.rb_pend == '0 && !s_ff.aw_got) |=>
            s_ff.rb_mom == '0;
    endproperty
    a_mom_clear: assert property (p_mom_clear)
        else $error("momentary remote bit lasted beyond one interval");

    property p_contacts_off;
        s_ff.ph != PH_RUN |=> latch_contact_drive == '0;
    endproperty
    a_contacts_off: assert property (p_contacts_off)
        else $error("contacts energized before restore finished");

    property p_nv_write;
        (s_ff.ph == PH_RUN && $changed(retained_latch_bit)) |->
            s_ff.nv_we && s_ff.nv_wdata[N-1:0] == retained_latch_bit
            ##1 s_ff.nv_we && s_ff.nv_waddr == NV_ADDR_CNT;
    endproperty
    a_nv_write: assert property (p_nv_write)
        else $error("latch change not written to the nonvolatile store");

    property p_fail;
        (s_ff.ph == PH_RUN && 32'(s_ff.wcount) >= ENDURANCE) |=>
            storage_fail ##1 storage_fail;
    endproperty
    a_fail: assert property (p_fail)
        else $error("endurance overrun not flagged as storage failure");

endmodule : rlb_latch_bank
`default_nettype wire

// *** tb/rlb_eq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Configured equations around the latch bank
// ==========================================================
module rlb_eq_model #(
    parameter int N = 8
) (
    input  wire logic         direct_en,
    input  wire logic [N-1:0] set_in,
    input  wire logic [N-1:0] clr_in,
    input  wire logic [N-1:0] src,
    input  wire logic [N-1:0] edge_pulse,
    input  wire logic [N-1:0] latch,
    input  wire logic         fb_en,
    input  wire logic         feedback_timer_output,
    input  wire logic         group_active_flag,
    input  wire logic         group_entry_delay_output,
    output logic      [N-1:0] operand,
    output logic      [N-1:0] set_term,
    output logic      [N-1:0] clr_term,
    output logic              reclose_lockout_drive
);
    // Opto or remote bit feeds the edge operator
    assign operand  = src;
    // Feedback steers each pulse to the opposite action
    logic [N-1:0] steer;
    // Timer variant steers bit 0 by the delayed latch copy
    assign steer    = {latch[N-1:1],
                       fb_en ? feedback_timer_output : latch[0]};
    assign set_term = direct_en ? set_in : edge_pulse & ~steer;
    assign clr_term = (direct_en ? clr_in : edge_pulse & steer)
        | N'({group_active_flag & ~group_entry_delay_output, 1'b0});
    assign reclose_lockout_drive = ~latch[0];
endmodule : rlb_eq_model
`default_nettype wire

// *** tb/test_retained_latch_bit_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_retained_latch_bit_bank import rlb_pkg::*;;
    localparam int N = 8;
    logic         aclk    = 1'b0;
    logic         aresetn = 1'b0;
    rlb_axi_req_t req     = '0;
    rlb_axi_rsp_t rsp;
    logic [N-1:0] set_in  = '0;
    logic [N-1:0] clr_in  = '0;
    logic [N-1:0] lat, cdrv, epul, rbit, op, st, ct;
    logic [5:0]   opto    = '0;
    logic [5:0]   odeb;
    logic         dir_en  = 1'b1;
    logic         fb_en = 1'b0, fb_t = 1'b0, grp = 1'b0, grp_dly = 1'b0;
    int           fb_cnt = 0;
    logic         tick, rdone, sfail, rld;
    logic [31:0]  d, e;
    logic [1:0]   r;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    int           cnt;

    // ==========================================================
    // Design and equations
    // ==========================================================
    rlb_latch_bank #(.N(N), .NOPTO(6), .INTERVAL_CYC(8), .DEB_TICKS(2),
        .ENDURANCE(3)) uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .latch_assert_term(st), .latch_clear_term(ct),
        .edge_operand(op), .opto_input(opto), .retained_latch_bit(lat),
        .latch_contact_drive(cdrv), .edge_pulse(epul), .remote_bit(rbit),
        .opto_debounced(odeb), .interval_tick(tick), .restore_done(rdone),
        .storage_fail(sfail));
    rlb_eq_model #(.N(N)) eq (.direct_en(dir_en), .set_in(set_in),
        .clr_in(clr_in), .src({rbit[N-1:1], odeb[0]}), .edge_pulse(epul),
        .latch(lat), .operand(op), .set_term(st), .clr_term(ct),
        .reclose_lockout_drive(rld), .fb_en(fb_en),
        .feedback_timer_output(fb_t), .group_active_flag(grp),
        .group_entry_delay_output(grp_dly));

    // Partner timers: entry delay and 300-interval feedback timer
    always @(posedge aclk) begin
        if (tick === 1'b1) begin
            grp_dly <= grp;
            fb_cnt  <= (lat[0] === fb_t) ? 0 : fb_cnt + 1;
            if (fb_cnt == 299 && lat[0] !== fb_t) fb_t <= lat[0];
        end
    end

    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk
    task results();
        $display("counts: %0d compared, %0d wrong", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // Returns just after the edge that ends the n-th tick cycle
    task ticks(input int n);
        repeat (n) begin
            @(posedge aclk);
            while (tick !== 1'b1) @(posedge aclk);
        end
        #1;
    endtask : ticks
    task wait_done();
        while (rdone !== 1'b1) @(posedge aclk);
        #1;
    endtask : wait_done
    task opulse();
        @(posedge aclk); opto[0] <= 1'b0;
        ticks(4);
        @(posedge aclk); opto[0] <= 1'b1;
        ticks(6);
    endtask : opulse
    task axw(input logic [7:0] a, input logic [31:0] dw,
             output logic [1:0] rs);
        @(posedge aclk);
        req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
        req.wdata <= dw; req.wstrb <= 4'hf; req.bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (rsp.awready !== 1'b1);
                req.awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (rsp.wready !== 1'b1);
                req.wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        rs = rsp.bresp;
        req.bready <= 1'b0;
    endtask : axw
    task axr(input logic [7:0] a, output logic [31:0] dr,
             output logic [1:0] rs);
        @(posedge aclk);
        req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        dr = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axr

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        void'($urandom(98));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        wait_done();
        chk("latch", lat, 0);
        axr(REG_STATUS, d, r);
        chk("status", d[0], 1);
        axr(8'h20, d, r);
        chk("resp", r, RESP_SLVERR);
        axw(REG_LATCH, 32'hff, r);
        chk("ro latch", lat, 0);
        $display("test restore done");
        // Set only, then both, then random terms
        e = '0;
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            set_in <= (i < 2) ? 8'hff : 8'($urandom);
            clr_in <= (i == 1) ? 8'hff : (i == 0) ? 8'h00 : 8'($urandom);
            ticks(1);
            e = (e | set_in) & ~clr_in;
            chk("latch", lat, e);
            @(posedge aclk);
            #1;
            chk("contact", cdrv, e);
        end
        @(posedge aclk); set_in <= '0; clr_in <= '1;
        ticks(1);
        @(posedge aclk); clr_in <= '0; dir_en <= 1'b0;
        $display("test set_clear done");
        // Opto held many intervals toggles once per assertion
        @(posedge aclk); opto[0] <= 1'b1;
        ticks(1);
        chk("debounce", lat[0], 0);
        ticks(8);
        chk("toggle", lat[0], 1);
        chk("lockout", rld, 0);
        chk("debounced", odeb[0], 1);
        opulse();
        chk("toggle", lat[0], 0);
        chk("lockout", rld, 1);
        @(posedge aclk); fb_en <= 1'b1;
        opulse();
        opulse();
        chk("timer hold", lat[0], 1);
        ticks(300);
        opulse();
        chk("timer clear", lat[0], 0);
        @(posedge aclk); fb_en <= 1'b0;
        $display("test toggle done");
        axw(REG_RB_PULSE, 32'h2, r);
        chk("bresp", r, RESP_OKAY);
        cnt = 0;
        repeat (6) begin
            ticks(1);
            cnt += int'(rbit[1] === 1'b1);
        end
        chk("momentary", cnt, 1);
        chk("remote toggle", lat[1], 1);
        axw(REG_RB_ON, 32'h4, r);
        ticks(6);
        axr(REG_LATCH, d, r);
        chk("latch reg", d, 32'h6);
        @(posedge aclk); grp <= 1'b1;
        ticks(2);
        chk("group entry", lat, 8'h04);
        $display("test remote done");
        // Power loss in mid-run
        @(posedge aclk); aresetn <= 1'b0; opto[0] <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk("contact", cdrv, 0);
        wait_done();
        chk("latch", lat, 8'h04);
        chk("remote", rbit, 0);
        ticks(3);
        chk("contact", cdrv, 8'h04);
        chk("latch", lat, 8'h04);
        axr(REG_STATUS, d, r);
        chk("fail", d[1], 1);
        chk("fail pin", sfail, 1);
        $display("test power done");
        results();
    end
endmodule : test_retained_latch_bit_bank
`default_nettype wire
